// File: sag_pad_model.sv
// pad model for the shared analog gpio port: resolves each two-way pin from both parties
// assumes a weak outside source that only shows where the port does not drive
`timescale 1ns/1ps
module sag_pad_model (
	// port side
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOe,
	// outside source
	input wire logic [7:0] extLevel,
	// level seen back at the port
	output logic [7:0] pinIn
);
	// a driven pin shows the port value, an undriven one the outside level
	assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// File: sag_params.svh
// constants of the shared analog gpio port: register indices, reset values, field positions
// assumes a 32-bit apb bus where each register takes one aligned word at byte address index*4
`ifndef SAG_PARAMS_SVH
`define SAG_PARAMS_SVH

// pins of the port
`define SAG_PINS 8
// register indices, byte address is four times the index
`define SAG_LATCH_IDX 12'h003
`define SAG_DIR_IDX 12'h00a
`define SAG_CONV_IDX 12'h00e
// reset values
`define SAG_LATCH_RST 8'h00
`define SAG_DIR_RST 8'h00
`define SAG_DIS_RST 1'h1
`define SAG_SEL_RST 3'h0
// converter control fields
`define SAG_SEL_LSB 0
`define SAG_WARN_BIT 5
`define SAG_BUSY_BIT 6
`define SAG_DIS_BIT 7
// pin groups sharing the port
`define SAG_ANA_LSB 2
`define SAG_ANA_CNT 6
`define SAG_KEY_LSB 4
`define SAG_KEY_CNT 4
`define SAG_TMR_CNT 2

`endif

// File: sag_pkg.sv
// types of the shared analog gpio port: apb carriers, register decode and the module state
// assumes sag_params.svh has been read before this package
package sag_pkg;

	// apb request from the bus master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} sag_apb_req_s;

	// apb answer to the bus master
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} sag_apb_rsp_s;

	// register that an address selects
	typedef enum logic [1:0] {
		SAG_REG_NONE,
		SAG_REG_LATCH,
		SAG_REG_DIR,
		SAG_REG_CONV
	} sag_reg_e;

	// state of the port apart from the channel select mirror
	typedef struct packed {
		logic [7:0] latch;
		logic [7:0] dir;
		logic anaDisable;
		logic [2:0] chanSel;
		logic writeWarn;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] pinOut;
		logic [7:0] pinOe;
		logic [5:0] anaEn;
		logic [3:0] keyWake;
		logic [1:0] tmrIn;
		sag_apb_rsp_s rsp;
	} sag_state_s;

endpackage

// File: sag_port.sv
// eight-bit general purpose port whose pins are shared with converter, key wakeup and timer lines
// assumes apb master on clk, pins arriving asynchronously, converter and timer logic on clk
`timescale 1ns/1ps
`include "sag_params.svh"

module sag_port (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire sag_pkg::sag_apb_req_s apbReq,
	output sag_pkg::sag_apb_rsp_s apbRsp,
	// pad side, three signals per two-way pin
	input wire logic [7:0] pinIn,
	output logic [7:0] pinOut,
	output logic [7:0] pinOe,
	// converter side
	input wire logic adcBusy,
	output logic [5:0] analogEnable,
	output logic [2:0] analogChannelSelect,
	// key wakeup side
	output logic [3:0] keyWakeupLine,
	// timer counter side
	input wire logic [1:0] timerOutEn,
	input wire logic [1:0] timerOutVal,
	output logic [1:0] timerCounterPin
);

	// registered state and its next value
	sag_pkg::sag_state_s s_r;
	sag_pkg::sag_state_s s_nxt;
	// chan select mirror so the converter sees the same field
	logic [2:0] chanSel_r;

	// decoded access terms
	logic access;
	logic done;
	sag_pkg::sag_reg_e regHit;
	logic [7:0] claimNow;
	logic [7:0] claimNext;
	logic [7:0] readByte;
	logic [7:0] convByte;

	// map a byte address onto a register
	function automatic sag_pkg::sag_reg_e regDecode(input logic [11:0] addr);
		sag_pkg::sag_reg_e r;
		r = sag_pkg::SAG_REG_NONE;
		if (addr == 12'(`SAG_LATCH_IDX << 2)) begin
			r = sag_pkg::SAG_REG_LATCH;
		end else if (addr == 12'(`SAG_DIR_IDX << 2)) begin
			r = sag_pkg::SAG_REG_DIR;
		end else if (addr == 12'(`SAG_CONV_IDX << 2)) begin
			r = sag_pkg::SAG_REG_CONV;
		end
		return r;
	endfunction

	// pins taken by the converter: one channel, only while analog is enabled
	function automatic logic [7:0] anaClaim(input logic dis, input logic [2:0] sel);
		logic [7:0] c;
		c = 8'h00;
		if (!dis && (sel < 3'(`SAG_ANA_CNT))) begin
			c = 8'(8'h01 << (sel + 3'(`SAG_ANA_LSB)));
		end
		return c;
	endfunction

	// value a port read returns, bit by bit
	function automatic logic [7:0] portRead(input logic [7:0] latch, input logic [7:0] dir,
		input logic [7:0] claim, input logic [7:0] level);
		logic [7:0] v;
		v = 8'h00;
		for (int i = 0; i < `SAG_PINS; i++) begin
			if (claim[i]) begin
				v[i] = latch[i];
			end else if (dir[i]) begin
				v[i] = latch[i];
			end else begin
				v[i] = level[i];
			end
		end
		return v;
	endfunction

	// reset image of the state struct, the channel select mirror resets on its own
	function automatic sag_pkg::sag_state_s resetState();
		sag_pkg::sag_state_s z;
		z = '0;
		z.latch = `SAG_LATCH_RST;
		z.dir = `SAG_DIR_RST;
		z.anaDisable = `SAG_DIS_RST;
		z.chanSel = `SAG_SEL_RST;
		return z;
	endfunction

	// access and decode terms
	always_comb begin
		access = apbReq.psel & apbReq.penable;
		done = access & s_r.rsp.pready;
		regHit = regDecode(apbReq.paddr);
		claimNow = anaClaim(s_r.anaDisable, s_r.chanSel);
		readByte = portRead(s_r.latch, s_r.dir, claimNow, s_r.sync2);
		convByte = 8'h00;
		convByte[`SAG_DIS_BIT] = s_r.anaDisable;
		convByte[`SAG_BUSY_BIT] = adcBusy;
		convByte[`SAG_WARN_BIT] = s_r.writeWarn;
		convByte[`SAG_SEL_LSB +: 3] = s_r.chanSel;
	end

	// next state of the port
	always_comb begin
		s_nxt = s_r;
		// two-stage synchroniser on the pads, second stage feeds logic
		s_nxt.sync1 = pinIn;
		s_nxt.sync2 = s_r.sync1;
		// one wait state, then the answer; pready drops after it was seen
		s_nxt.rsp.pready = access & ~s_r.rsp.pready;
		s_nxt.rsp.pslverr = 1'b0;
		s_nxt.rsp.prdata = 32'h0;
		if (access && !s_r.rsp.pready) begin
			// read data and error are fixed one cycle before the sampling edge
			unique case (regHit)
				sag_pkg::SAG_REG_LATCH: begin
					s_nxt.rsp.prdata = {24'h0, readByte};
				end
				sag_pkg::SAG_REG_DIR: begin
					s_nxt.rsp.prdata = {24'h0, s_r.dir};
				end
				sag_pkg::SAG_REG_CONV: begin
					s_nxt.rsp.prdata = {24'h0, convByte};
				end
				sag_pkg::SAG_REG_NONE: begin
					// unmapped word answers zero with an error
					s_nxt.rsp.pslverr = 1'b1;
				end
			endcase
		end
		// writes land on the edge at which pready is sampled
		if (done && apbReq.pwrite) begin
			unique case (regHit)
				sag_pkg::SAG_REG_LATCH: begin
					// latch always takes the data, even on analog pins
					s_nxt.latch = apbReq.pwdata[7:0];
				end
				sag_pkg::SAG_REG_DIR: begin
					s_nxt.dir = apbReq.pwdata[7:0];
				end
				sag_pkg::SAG_REG_CONV: begin
					s_nxt.anaDisable = apbReq.pwdata[`SAG_DIS_BIT];
					s_nxt.chanSel = apbReq.pwdata[`SAG_SEL_LSB +: 3];
				end
				sag_pkg::SAG_REG_NONE: begin
					// nothing stored
				end
			endcase
		end
		// sticky warning of a port write during conversion, set beats clear
		if (done && apbReq.pwrite && (regHit == sag_pkg::SAG_REG_CONV) && apbReq.pwdata[`SAG_WARN_BIT]) begin
			s_nxt.writeWarn = 1'b0;
		end
		if (done && apbReq.pwrite && (regHit == sag_pkg::SAG_REG_LATCH) && adcBusy) begin
			s_nxt.writeWarn = 1'b1;
		end
		// pad drive follows the new register values
		claimNext = anaClaim(s_nxt.anaDisable, s_nxt.chanSel);
		s_nxt.pinOe = s_nxt.dir & ~claimNext;
		s_nxt.pinOut = s_nxt.latch & ~claimNext;
		for (int t = 0; t < `SAG_TMR_CNT; t++) begin
			// timer output replaces the latch value on the low pins when it is enabled, the enables still follow dir
			if (timerOutEn[t]) begin
				s_nxt.pinOut[t] = timerOutVal[t];
			end
		end
		s_nxt.anaEn = claimNext[`SAG_ANA_LSB +: `SAG_ANA_CNT];
		// wakeup lines see only pins left in input mode
		s_nxt.keyWake = s_r.sync2[`SAG_KEY_LSB +: `SAG_KEY_CNT] & ~s_nxt.dir[`SAG_KEY_LSB +: `SAG_KEY_CNT];
		s_nxt.tmrIn = s_r.sync2[0 +: `SAG_TMR_CNT];
	end

	// state register with synchronous reset
	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= resetState();
		end else begin
			s_r <= s_nxt;
		end
	end

	// converter channel select mirror
	always_ff @(posedge clk) begin
		if (rst) begin
			chanSel_r <= `SAG_SEL_RST;
		end else begin
			chanSel_r <= s_nxt.chanSel;
		end
	end

	// outputs straight from the state register, channel select from its mirror register
	assign apbRsp = s_r.rsp;
	assign pinOut = s_r.pinOut;
	assign pinOe = s_r.pinOe;
	assign analogEnable = s_r.anaEn;
	assign analogChannelSelect = chanSel_r;
	assign keyWakeupLine = s_r.keyWake;
	assign timerCounterPin = s_r.tmrIn;

	// checks on the clk domain
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// start values after reset
	chk_reset_values: assert property ($past(rst) |-> (pinOe == 8'h00) && (s_r.latch == 8'h00) && s_r.anaDisable && (analogEnable == 6'h00))
		else $error("reset values wrong");

	// a direction write shows on the enables one edge later
	chk_dir_oe: assert property (done && apbReq.pwrite && (regHit == sag_pkg::SAG_REG_DIR)
		|=> pinOe == ($past(apbReq.pwdata[7:0]) & ~{analogEnable, 2'b00}))
		else $error("direction write not seen on enables");

	// analog pins are never driven
	chk_ana_nodrive: assert property ((pinOe & {analogEnable, 2'b00}) == 8'h00)
		else $error("analog pin driven");

	// disable low with channel 1 chosen selects exactly that channel
	chk_ana_select: assert property (done && apbReq.pwrite && (regHit == sag_pkg::SAG_REG_CONV)
		&& !apbReq.pwdata[`SAG_DIS_BIT] && (apbReq.pwdata[2:0] == 3'h1) |=> analogEnable == 6'h02)
		else $error("analog channel not claimed");

	// a latch write drives the new value on output pins
	chk_latch_drive: assert property (done && apbReq.pwrite && (regHit == sag_pkg::SAG_REG_LATCH) && (timerOutEn == 2'b00)
		|=> (pinOut == ($past(apbReq.pwdata[7:0]) & ~{analogEnable, 2'b00})) && (s_r.latch == $past(apbReq.pwdata[7:0])))
		else $error("latch write not driven");

	// input pins read back the synchronised level
	chk_input_read: assert property (access && !s_r.rsp.pready && !apbReq.pwrite && (regHit == sag_pkg::SAG_REG_LATCH)
		|=> (apbRsp.prdata[7:0] & ~$past(s_r.dir | claimNow)) == ($past(s_r.sync2) & ~$past(s_r.dir | claimNow)))
		else $error("input pin read wrong");

	// analog pins read back the latch
	chk_claim_read: assert property (access && !s_r.rsp.pready && !apbReq.pwrite && (regHit == sag_pkg::SAG_REG_LATCH)
		|=> (apbRsp.prdata[7:0] & $past(claimNow)) == ($past(s_r.latch) & $past(claimNow)))
		else $error("analog pin read wrong");

	// one wait state, then a single answer cycle
	chk_apb_wait: assert property (access && !apbRsp.pready |=> apbRsp.pready ##1 !apbRsp.pready)
		else $error("apb answer timing wrong");

	// unmapped words answer with an error
	chk_apb_error: assert property (access && !apbRsp.pready && (regHit == sag_pkg::SAG_REG_NONE) |=> apbRsp.pslverr)
		else $error("unmapped access without error");

	// port write during conversion raises the warning
	chk_warn_set: assert property (done && apbReq.pwrite && (regHit == sag_pkg::SAG_REG_LATCH) && adcBusy |=> s_r.writeWarn)
		else $error("conversion write warning missed");

	// wakeup lines stay low on output pins
	chk_key_wake: assert property ((keyWakeupLine & s_r.dir[7:4]) == 4'h0)
		else $error("wakeup from output pin");

	// wakeup lines carry the synchronised level of input pins
	chk_key_level: assert property (keyWakeupLine == ($past(s_r.sync2[7:4]) & ~s_r.dir[7:4]))
		else $error("wakeup line level wrong");

	// timer input lines carry the synchronised level of the low pins
	chk_timer_in: assert property (timerCounterPin == $past(s_r.sync2[1:0]))
		else $error("timer input level wrong");

	// reset leaves every pin output low and direction and channel select cleared
	chk_reset_regs: assert property ($past(rst) |-> (s_r.dir == 8'h00) && (pinOut == 8'h00) && (s_r.chanSel == 3'h0))
		else $error("register reset values wrong");

	// an input-mode pin is never driven
	chk_input_undriven: assert property ((pinOe & ~s_r.dir) == 8'h00)
		else $error("input pin driven");

	// with analog disabled no pin is claimed
	chk_disable_idle: assert property (s_r.anaDisable |-> analogEnable == 6'h00)
		else $error("analog claim while disabled");

	// at most one converter channel at a time
	chk_one_channel: assert property ($onehot0(analogEnable))
		else $error("more than one analog channel");

	// the converter sees the same channel field as the register
	chk_sel_mirror: assert property (analogChannelSelect == s_r.chanSel)
		else $error("channel select mirror differs");

	// the answer stands for a single cycle
	chk_ready_single: assert property (apbRsp.pready |=> !apbRsp.pready)
		else $error("pready held too long");

	// error only comes with the answer
	chk_err_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
		else $error("pslverr without pready");

	// eight-bit registers read zero in the upper bits
	chk_upper_zero: assert property (apbRsp.pready |-> apbRsp.prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");

	// main scenarios
	cov_analog_on: cover property (analogEnable != 6'h00);
	cov_mixed_read: cover property (done && !apbReq.pwrite && (regHit == sag_pkg::SAG_REG_LATCH) && (s_r.dir != 8'h00) && (s_r.dir != 8'hff));
	cov_warn: cover property (s_r.writeWarn);
	cov_timer_out: cover property (timerOutEn != 2'b00 && pinOe[0]);
	// an unmapped word was answered with an error
	cov_unmapped: cover property (apbRsp.pslverr);

endmodule

// File: tb_top.sv
// self-checking bench for the shared analog gpio port over apb
// assumes sag_port, sag_pkg and the pad model are compiled before it
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {logic wr; logic [11:0] addr; logic [31:0] data; logic err;} sag_row_s;
	// clock, reset and bus
	logic clk;
	logic rst;
	sag_pkg::sag_apb_req_s req;
	sag_pkg::sag_apb_rsp_s rsp;
	// pins and side lines
	logic [7:0] pinIn, pinOut, pinOe, extLevel;
	logic adcBusy;
	logic [5:0] anaEn;
	logic [2:0] chanSel;
	logic [3:0] keyWake;
	logic [1:0] tmrEn, tmrVal, tmrPin;
	// results of the last transfer
	logic [31:0] rdata;
	logic rerr;
	int num_errors;
	int checks;
	sag_row_s rows [9];
	sag_port i_dut (.clk(clk), .rst(rst), .apbReq(req), .apbRsp(rsp), .pinIn(pinIn), .pinOut(pinOut),
		.pinOe(pinOe), .adcBusy(adcBusy), .analogEnable(anaEn), .analogChannelSelect(chanSel),
		.keyWakeupLine(keyWake), .timerOutEn(tmrEn), .timerOutVal(tmrVal), .timerCounterPin(tmrPin));
	sag_pad_model i_pad (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn));
	// free running clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// counts a comparison and reports a mismatch
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	// prints the counts and the verdict, then ends the run
	task automatic final_report();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// one apb transfer: setup, access held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= wr;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (rsp.pready !== 1'b1) begin
			num_errors++;
			final_report();
		end
		rdata = rsp.prdata;
		rerr = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	// main sequence
	initial begin
		rst = 1'b1;
		req = '0;
		adcBusy = 1'b0;
		tmrEn = 2'h0;
		tmrVal = 2'h0;
		extLevel = 8'h52;
		num_errors = 0;
		checks = 0;
		rows = '{'{1'b0, 12'h028, 32'h00, 1'b0}, '{1'b0, 12'h038, 32'h80, 1'b0}, '{1'b0, 12'h00c, 32'h52, 1'b0},
			'{1'b1, 12'h028, 32'h07, 1'b0}, '{1'b1, 12'h00c, 32'had, 1'b0}, '{1'b0, 12'h028, 32'h07, 1'b0},
			'{1'b0, 12'h00c, 32'h55, 1'b0}, '{1'b0, 12'h010, 32'h00, 1'b1}, '{1'b1, 12'h014, 32'hff, 1'b1}};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		// register rows: reset values, direction, latch, input readback, unmapped
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].addr, rows[i].data);
			if (!rows[i].wr) chk("prdata", rows[i].data, rdata);
			chk("pslverr", {31'h0, rows[i].err}, {31'h0, rerr});
		end
		repeat (4) @(posedge clk);
		chk("pinOe", 32'h07, {24'h0, pinOe});
		chk("pinOut", 32'h05, {24'h0, pinOut & 8'h07});
		chk("keyWake", 32'h5, {28'h0, keyWake});
		chk("tmrPin", 32'h1, {30'h0, tmrPin});
		// analog claim of channel 1, pin 3, then try to drive it
		apb(1'b1, 12'h038, 32'h01);
		apb(1'b1, 12'h028, 32'h0f);
		repeat (4) @(posedge clk);
		chk("anaEn", 32'h02, {26'h0, anaEn});
		chk("pinOe", 32'h07, {24'h0, pinOe});
		apb(1'b0, 12'h00c, 32'h0);
		chk("prdata", 32'h5d, rdata);
		// write while converting raises the warning
		adcBusy <= 1'b1;
		apb(1'b1, 12'h00c, 32'h0d);
		apb(1'b0, 12'h038, 32'h0);
		chk("conv", 32'h61, rdata);
		apb(1'b0, 12'h00c, 32'h0);
		chk("latch", 32'h5d, rdata);
		// timer override on pin 0; output flop, two sync stages and timer input flop need four edges, the check comes later
		adcBusy <= 1'b0;
		tmrEn <= 2'h1;
		tmrVal <= 2'h0;
		repeat (6) @(posedge clk);
		chk("tmrPin", 32'h0, {30'h0, tmrPin});
		// second reset in mid-run
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("pinOe", 32'h0, {24'h0, pinOe});
		chk("anaEn", 32'h0, {26'h0, anaEn});
		apb(1'b0, 12'h038, 32'h0);
		chk("conv", 32'h80, rdata);
		final_report();
	end
endmodule
